// ==== hw/dma_bm_pkg.sv ====
// Shared constants and types of the DMA bus-master signalling block
package dma_bm_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;                 // Channels served
    localparam int ADDR_W = 16;                // Transfer address width
    localparam int UPPER_LSB = 8;              // First bit of the upper address byte
    localparam int MID_LSB = 4;                // First bit of the middle nibble
    // ------------------------------------------------------------
    // Transfer types
    // ------------------------------------------------------------
    localparam logic [1:0] XFER_VERIFY = 2'h0; // No memory strobe
    localparam logic [1:0] XFER_WRITE = 2'h1;  // Peripheral to memory
    localparam logic [1:0] XFER_READ = 2'h2;   // Memory to peripheral
    localparam logic [1:0] XFER_MEM2MEM = 2'h3;// Memory to memory
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic ACK_POL_RESET = 1'b0;     // Acknowledge active low after reset
    localparam logic STROBE_IDLE = 1'b1;       // Inactive level of low-true strobes
    // Service states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD_WAIT,
        ST_ADDR_UPDATE,
        ST_XFER2,
        ST_XFER3,
        ST_XFER4
    } state_t;
endpackage

// ==== hw/req_sel_if.sv ====
// Carrier between the top and the request selector
`timescale 1ns/1ps
interface req_sel_if #(parameter int CH = 4);
    logic [CH-1:0] req_raw;   // Asynchronous peripheral requests
    logic [CH-1:0] mask;      // Mask bits, set means ignored
    logic [CH-1:0] sw_req;    // Software requests
    logic pending;            // Some channel wants service
    logic [CH-1:0] chan_oh;   // Winning channel, one-hot
    modport sel (input req_raw, input mask, input sw_req, output pending, output chan_oh);
    modport top (output req_raw, output mask, output sw_req, input pending, input chan_oh);
endinterface

// ==== hw/req_select.sv ====
// Request synchroniser and fixed-priority channel pick
`timescale 1ns/1ps
module req_select #(
    parameter int CH = 4
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    req_sel_if.sel rq
);
    logic [CH-1:0] meta_r;   // First synchroniser stage
    logic [CH-1:0] sync_r;   // Second synchroniser stage
    logic [CH-1:0] want;     // Requests eligible for service

    // ------------------------------------------------------------
    // Two-stage synchroniser for the asynchronous request pins
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= rq.req_raw;
            sync_r <= meta_r;
        end
    end

    // Unmasked hardware requests or software requests
    assign want = (sync_r & ~rq.mask) | rq.sw_req; // R2
    // Lowest index wins
    assign rq.chan_oh = want & (~want + {{(CH-1){1'b0}}, 1'b1});
    assign rq.pending = |want; // R2
endmodule // req_select

// ==== hw/dma_bus_master.sv ====
// Bus-master sequencing and pin drive of a four-channel DMA controller
`timescale 1ns/1ps
// What this block does
// R1: Middle nibble driven only during service
// R2: Hold request on unmasked or software request
// R3: Buses taken only after hold grant
// R4: Looped grant gives exactly one wait
// R5: Acknowledge granted channel, polarity, reset low
// R6: Upper drive enable high during transfers
// R7: Latch strobe pulses to capture upper byte
// R8: Skip address update when upper byte same
// R9: Latch strobe timed from falling edge
// R10: Memory read strobe low on reads
// R11: Memory write strobe low on writes
// R12: Upper address byte on data pins
// R13: Low nibble out when active only
// R14: Peripheral holds request until acknowledged
// R15: Release everything when service ends
module dma_bus_master #(
    parameter int CH = dma_bm_pkg::NUM_CH
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [CH-1:0] channel_request_i,    // Asynchronous peripheral requests
    input wire logic [CH-1:0] channel_mask_i,       // Mask bits
    input wire logic [CH-1:0] sw_request_i,         // Software requests
    input wire logic ack_active_high_i,             // Acknowledge polarity, taken while idle
    input wire logic [1:0] xfer_type_i,             // Transfer type
    input wire logic block_mode_i,                  // Block rather than single transfer
    input wire logic [dma_bm_pkg::ADDR_W-1:0] start_addr_i, // Source address
    input wire logic [dma_bm_pkg::ADDR_W-1:0] dest_addr_i,  // Destination for memory to memory
    input wire logic [dma_bm_pkg::ADDR_W-1:0] word_count_i, // Transfers minus one
    input wire logic bus_hold_grant_i,              // Grant from the host, same clock
    output logic bus_hold_request_o,
    output logic [CH-1:0] channel_acknowledge_o,
    output logic upper_addr_drive_enable_o,
    output logic upper_addr_latch_strobe_o,
    output logic [3:0] addr_mid_nibble_o,
    output logic addr_mid_nibble_oe_o,
    output logic [3:0] addr_low_nibble_o,
    output logic addr_low_nibble_oe_o,
    output logic [7:0] data_bus_o,
    output logic data_bus_oe_o,
    output logic mem_read_strobe_n_o,
    output logic mem_read_strobe_oe_o,
    output logic mem_write_strobe_n_o,
    output logic mem_write_strobe_oe_o
);
    localparam int AW = dma_bm_pkg::ADDR_W;
    localparam int UL = dma_bm_pkg::UPPER_LSB;
    localparam int ML = dma_bm_pkg::MID_LSB;

    initial begin
        if (CH < 1 || CH > 8) begin
            $error("CH must lie between 1 and 8");
        end
    end

    // ------------------------------------------------------------
    // Request selection
    // ------------------------------------------------------------
    req_sel_if #(.CH(CH)) rq ();
    assign rq.req_raw = channel_request_i;
    assign rq.mask = channel_mask_i;
    assign rq.sw_req = sw_request_i;

    req_select #(.CH(CH)) u_sel (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .rq(rq)
    );

    dma_bm_pkg::state_t state_r;          // Current service state
    dma_bm_pkg::state_t state_nxt;        // Next service state
    logic [AW-1:0] src_r;                 // Source or single address
    logic [AW-1:0] dst_r;                 // Destination address
    logic [AW-1:0] cnt_r;                 // Remaining transfers minus one
    logic [1:0] type_r;                   // Transfer type of this service
    logic block_r;                        // Block service
    logic phase_r;                        // Write half of memory to memory
    logic phase_nxt;
    logic [CH-1:0] chan_r;                // Channel being served
    logic ack_pol_r;                      // Acknowledge polarity, high means active high
    logic [7:0] upper_r;                  // Upper byte held in the external latch
    logic [AW-1:0] cur_addr;              // Address of the half in progress
    logic [AW-1:0] next_addr;             // Address of the following half
    logic [AW-1:0] addr_nxt;              // Address shown after this edge
    logic last_step;                      // Service finishes at this step
    logic active_nxt;                     // Bus owned in the next state
    logic rd_nxt;                         // Read strobe low in the next state
    logic wr_nxt;                         // Write strobe low in the next state

    assign cur_addr = phase_r ? dst_r : src_r;
    assign last_step = !block_r || (cnt_r == '0);

    // Address that follows the current half
    always_comb begin
        next_addr = src_r + {{(AW-1){1'b0}}, 1'b1};
        if (type_r == dma_bm_pkg::XFER_MEM2MEM) begin
            next_addr = phase_r ? (src_r + {{(AW-1){1'b0}}, 1'b1}) : dst_r;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        case (state_r)
            dma_bm_pkg::ST_IDLE: begin
                // Request the buses
                if (rq.pending) begin
                    state_nxt = dma_bm_pkg::ST_HOLD_WAIT; // R2
                end
                phase_nxt = 1'b0;
            end
            dma_bm_pkg::ST_HOLD_WAIT: begin
                // Stay until the host releases the buses
                if (bus_hold_grant_i) begin
                    state_nxt = dma_bm_pkg::ST_ADDR_UPDATE; // R3 R4
                end
            end
            dma_bm_pkg::ST_ADDR_UPDATE: state_nxt = dma_bm_pkg::ST_XFER2;
            dma_bm_pkg::ST_XFER2: state_nxt = dma_bm_pkg::ST_XFER3;
            dma_bm_pkg::ST_XFER3: state_nxt = dma_bm_pkg::ST_XFER4;
            dma_bm_pkg::ST_XFER4: begin
                if (type_r == dma_bm_pkg::XFER_MEM2MEM && !phase_r) begin
                    // Write half follows the read half
                    phase_nxt = 1'b1;
                    state_nxt = (next_addr[AW-1:UL] != upper_r) ? dma_bm_pkg::ST_ADDR_UPDATE
                                                                : dma_bm_pkg::ST_XFER2; // R8
                end else if (last_step) begin
                    phase_nxt = 1'b0;
                    state_nxt = dma_bm_pkg::ST_IDLE; // R15
                end else begin
                    // Update the latch only when the upper byte moves
                    phase_nxt = 1'b0;
                    state_nxt = (next_addr[AW-1:UL] != upper_r) ? dma_bm_pkg::ST_ADDR_UPDATE
                                                                : dma_bm_pkg::ST_XFER2; // R8
                end
            end
            default: state_nxt = dma_bm_pkg::ST_IDLE;
        endcase
    end

    // Address that the pins show after this edge
    assign addr_nxt = (state_r == dma_bm_pkg::ST_XFER4 && state_nxt != dma_bm_pkg::ST_IDLE) ? next_addr
                    : (state_r == dma_bm_pkg::ST_HOLD_WAIT) ? src_r : cur_addr;
    assign active_nxt = (state_nxt != dma_bm_pkg::ST_IDLE) && (state_nxt != dma_bm_pkg::ST_HOLD_WAIT);
    assign rd_nxt = (state_nxt == dma_bm_pkg::ST_XFER2 || state_nxt == dma_bm_pkg::ST_XFER3 ||
                     state_nxt == dma_bm_pkg::ST_XFER4) &&
                    (type_r == dma_bm_pkg::XFER_READ ||
                     (type_r == dma_bm_pkg::XFER_MEM2MEM && !phase_nxt)); // R10
    assign wr_nxt = (state_nxt == dma_bm_pkg::ST_XFER3 || state_nxt == dma_bm_pkg::ST_XFER4) &&
                    (type_r == dma_bm_pkg::XFER_WRITE ||
                     (type_r == dma_bm_pkg::XFER_MEM2MEM && phase_nxt)); // R11

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= dma_bm_pkg::ST_IDLE;
            phase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
        end
    end

    // Service setup when leaving idle, addresses step after each transfer but the last
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            src_r <= '0;
            dst_r <= '0;
            cnt_r <= '0;
            type_r <= dma_bm_pkg::XFER_VERIFY;
            block_r <= 1'b0;
            chan_r <= '0;
        end else if (state_r == dma_bm_pkg::ST_IDLE && rq.pending) begin
            src_r <= start_addr_i;
            dst_r <= dest_addr_i;
            cnt_r <= word_count_i;
            type_r <= xfer_type_i;
            block_r <= block_mode_i;
            chan_r <= rq.chan_oh;
        end else if (state_r == dma_bm_pkg::ST_XFER4 && !last_step &&
                     (type_r != dma_bm_pkg::XFER_MEM2MEM || phase_r)) begin
            src_r <= src_r + {{(AW-1){1'b0}}, 1'b1};
            if (type_r == dma_bm_pkg::XFER_MEM2MEM) begin
                dst_r <= dst_r + {{(AW-1){1'b0}}, 1'b1};
            end
            cnt_r <= cnt_r - {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // Polarity follows its input only while idle
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_pol_r <= dma_bm_pkg::ACK_POL_RESET; // R5
        end else if (state_r == dma_bm_pkg::ST_IDLE) begin
            ack_pol_r <= ack_active_high_i;
        end
    end

    // Upper byte that the external latch holds
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_r <= '0;
        end else if (state_r == dma_bm_pkg::ST_ADDR_UPDATE) begin
            upper_r <= cur_addr[AW-1:UL]; // R8
        end
    end

    // ------------------------------------------------------------
    // Registered pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_hold_request_o <= 1'b0;
            upper_addr_drive_enable_o <= 1'b0;
            channel_acknowledge_o <= {CH{1'b1}};
            addr_mid_nibble_o <= '0;
            addr_mid_nibble_oe_o <= 1'b0;
            addr_low_nibble_o <= '0;
            addr_low_nibble_oe_o <= 1'b0;
            data_bus_o <= '0;
            data_bus_oe_o <= 1'b0;
            mem_read_strobe_n_o <= dma_bm_pkg::STROBE_IDLE;
            mem_read_strobe_oe_o <= 1'b0;
            mem_write_strobe_n_o <= dma_bm_pkg::STROBE_IDLE;
            mem_write_strobe_oe_o <= 1'b0;
        end else begin
            bus_hold_request_o <= (state_nxt != dma_bm_pkg::ST_IDLE); // R2 R15
            upper_addr_drive_enable_o <= active_nxt; // R6 R3
            // Only the served channel, in the chosen sense
            channel_acknowledge_o <= ((state_r == dma_bm_pkg::ST_IDLE ? ack_active_high_i : ack_pol_r)
                                      ? (active_nxt ? chan_r : '0) : ~(active_nxt ? chan_r : '0)); // R5
            addr_mid_nibble_o <= addr_nxt[UL-1:ML]; // R1
            addr_mid_nibble_oe_o <= active_nxt; // R1
            addr_low_nibble_o <= addr_nxt[ML-1:0]; // R13
            addr_low_nibble_oe_o <= active_nxt; // R13
            data_bus_o <= addr_nxt[AW-1:UL]; // R12
            data_bus_oe_o <= active_nxt; // R12
            mem_read_strobe_n_o <= !rd_nxt; // R10
            mem_read_strobe_oe_o <= active_nxt; // R10
            mem_write_strobe_n_o <= !wr_nxt; // R11
            mem_write_strobe_oe_o <= active_nxt; // R11
        end
    end

    // Latch strobe launched on the falling edge through the update state
    always_ff @(negedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_addr_latch_strobe_o <= 1'b0;
        end else begin
            upper_addr_latch_strobe_o <= (state_r == dma_bm_pkg::ST_ADDR_UPDATE); // R7 R9
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_hold_rise;
        $rose(bus_hold_request_o) ##0 bus_hold_grant_i;
    endsequence
    sequence s_one_wait;
        upper_addr_drive_enable_o ##0 (state_r == dma_bm_pkg::ST_ADDR_UPDATE);
    endsequence

    AST_HOLD_CAUSE: assert property ($rose(bus_hold_request_o) |-> $past(rq.pending)) // R2
        else $error("hold request rose without a request");
    AST_GRANT_FIRST: assert property ($rose(upper_addr_drive_enable_o) |-> $past(bus_hold_grant_i)) // R3
        else $error("buses taken without grant");
    AST_ONE_WAIT: assert property (s_hold_rise |=> s_one_wait) // R4
        else $error("looped grant did not give one wait state");
    AST_MID_WINDOW: assert property (addr_mid_nibble_oe_o == upper_addr_drive_enable_o) // R1
        else $error("middle nibble drive outside service");
    AST_ACK_ONEHOT: assert property (upper_addr_drive_enable_o |->
        $onehot(ack_pol_r ? channel_acknowledge_o : ~channel_acknowledge_o)) // R5
        else $error("acknowledge not one channel");
    AST_ACK_QUIET: assert property (!upper_addr_drive_enable_o |->
        channel_acknowledge_o == (ack_pol_r ? {CH{1'b0}} : {CH{1'b1}})) // R5
        else $error("acknowledge active outside service");
    AST_LATCH_CURRENT: assert property (state_r == dma_bm_pkg::ST_XFER2 |->
        upper_r == cur_addr[AW-1:UL] && data_bus_o == upper_r) // R8 R12
        else $error("upper byte stale without update state");
    AST_STROBE_EDGE: assert property (@(negedge clock_i) disable iff (!arst_n_i)
        upper_addr_latch_strobe_o == $past(state_r == dma_bm_pkg::ST_ADDR_UPDATE)) // R9 R7
        else $error("latch strobe not tied to update state");
    AST_STROBES_APART: assert property (!(mem_read_strobe_n_o == 1'b0 && mem_write_strobe_n_o == 1'b0)
        and (mem_read_strobe_n_o == 1'b0 |-> mem_read_strobe_oe_o)) // R10 R11
        else $error("memory strobes overlap or float");
    AST_RELEASE: assert property (state_r == dma_bm_pkg::ST_IDLE |->
        !bus_hold_request_o && !data_bus_oe_o && !mem_read_strobe_oe_o) // R15
        else $error("pins driven while idle");
endmodule // dma_bus_master

// ==== verif/host_hold_model.sv ====
// Host model that releases the buses and grants bus hold
`timescale 1ns/1ps
module host_hold_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic hold_request_i,  // Hold request from the block
    input wire logic loopback_i,      // Request wired straight back as grant
    input wire logic [3:0] delay_i,   // Cycles the host needs to release the buses
    output logic hold_grant_o
);
    // ------------------------------------------------------------
    // Grant sequencing
    // ------------------------------------------------------------
    logic [3:0] wait_r;  // Cycles the request has waited
    logic grant_r;       // Grant, given only after the buses are released
    // Count the release time, withdraw the grant with the request
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_r <= 4'h0;
            grant_r <= 1'b0;
        end else if (!hold_request_i) begin
            wait_r <= 4'h0;
            grant_r <= 1'b0;
        end else begin
            // Saturate so a long hold never wraps
            if (wait_r != 4'hf) begin
                wait_r <= wait_r + 4'h1;
            end
            grant_r <= (wait_r >= delay_i);
        end
    end
    // Stand-alone use ties the request to the grant
    assign hold_grant_o = loopback_i ? hold_request_i : grant_r;
endmodule // host_hold_model

// ==== verif/dma_bus_master_signals_tb_top.sv ====
// Self-checking testbench of the DMA bus-master signalling block
`timescale 1ns/1ps
module dma_bus_master_signals_tb_top;
    // ------------------------------------------------------------
    // Stimulus rows
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] req; logic [3:0] mask; logic [3:0] sw; logic pol; logic [1:0] typ; logic blk;
        logic [15:0] addr; logic [15:0] cnt; logic loop; logic [3:0] dly;
        logic [7:0] rd; logic [7:0] wr; logic [7:0] stb;
    } row_t;
    row_t rows [8];
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] req = 4'h0, mask = 4'h0, sw = 4'h0, dly = 4'h0;
    logic pol = 1'b0, blk = 1'b0, loop = 1'b1;
    logic [1:0] typ = 2'h0;
    logic [15:0] saddr = 16'h0, daddr = 16'h0, cnt = 16'h0, cur_addr = 16'h0;
    logic grant, bus_hold_request, upper_addr_drive_enable, stb, mid_oe, low_oe, data_oe, rd_n, rd_oe, wr_n, wr_oe;
    logic [3:0] ack, mid, low, active;
    logic [7:0] data;
    int failures = 0, checks_done = 0, n_rd, n_wr, n_stb, n_wait, k;
    logic seen_aen, prev_stb = 1'b0, s_hold;
    logic [3:0] served_q [$];
    // ------------------------------------------------------------
    // Design, host model, clock
    // ------------------------------------------------------------
    dma_bus_master #(.CH(4)) uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .channel_request_i(req),
        .channel_mask_i(mask), .sw_request_i(sw), .ack_active_high_i(pol), .xfer_type_i(typ),
        .block_mode_i(blk), .start_addr_i(saddr), .dest_addr_i(daddr), .word_count_i(cnt),
        .bus_hold_grant_i(grant), .bus_hold_request_o(bus_hold_request), .channel_acknowledge_o(ack),
        .upper_addr_drive_enable_o(upper_addr_drive_enable), .upper_addr_latch_strobe_o(stb), .addr_mid_nibble_o(mid),
        .addr_mid_nibble_oe_o(mid_oe), .addr_low_nibble_o(low), .addr_low_nibble_oe_o(low_oe),
        .data_bus_o(data), .data_bus_oe_o(data_oe), .mem_read_strobe_n_o(rd_n),
        .mem_read_strobe_oe_o(rd_oe), .mem_write_strobe_n_o(wr_n), .mem_write_strobe_oe_o(wr_oe));
    host_hold_model host (.clock_i(clock_i), .arst_n_i(arst_n_i), .hold_request_i(bus_hold_request),
        .loopback_i(loop), .delay_i(dly), .hold_grant_o(grant));
    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Pin monitor, also plays the peripherals
    // ------------------------------------------------------------
    always @(posedge clock_i) begin
        if (arst_n_i) begin
            active = pol ? ack : ~ack;
            // Idle: nothing driven
            if (!bus_hold_request) begin
                check("idle_drive", 16'h0, {upper_addr_drive_enable, mid_oe, low_oe, data_oe, rd_oe | wr_oe});
                // Next service records its first bus cycle afresh
                seen_aen = 1'b0;
            end
            if (bus_hold_request && !upper_addr_drive_enable && !seen_aen) n_wait++;
            if (upper_addr_drive_enable) begin
                check("ack_onehot", 16'h1, $onehot(active));
                check("aen_grant", 16'h1, grant);
                check("pins_on", 16'h7, {mid_oe, low_oe, data_oe});
                // First bus cycle shows the start address
                if (!seen_aen) begin
                    served_q.push_back(active);
                    check("mid_nibble", cur_addr[7:4], mid);
                    check("low_nibble", cur_addr[3:0], low);
                end
                seen_aen = 1'b1;
                n_rd += (rd_n === 1'b0);
                n_wr += (wr_n === 1'b0);
                // Peripheral holds its request until acknowledged
                req <= req & ~active;
                sw <= sw & ~active;
            end
            // Each latch strobe falls in service, the first one carries the upper address byte
            if (stb && !prev_stb) begin
                n_stb++;
                check("strobe_in_service", 16'h1, upper_addr_drive_enable);
                if (n_stb == 1) check("upper_byte", cur_addr[15:8], data);
            end
            prev_stb = stb;
        end
    end
    // Latch strobe must not move at the rising edge
    always @(posedge clock_i) begin
        s_hold = stb;
        #5;
        if (arst_n_i) check("strobe_edge", s_hold, stb);
    end
    // ------------------------------------------------------------
    // Shared sequences
    // ------------------------------------------------------------
    task automatic wait_hrq(input logic v, input int lim);
        k = 0;
        while (bus_hold_request !== v && k < lim) begin
            @(posedge clock_i);
            k++;
        end
        check("hrq_wait", v, bus_hold_request);
    endtask
    task automatic run_row(input row_t r);
        @(negedge clock_i);
        n_rd = 0; n_wr = 0; n_stb = 0; n_wait = 0; seen_aen = 1'b0; cur_addr = r.addr;
        served_q.delete();
        @(posedge clock_i);
        mask <= r.mask; pol <= r.pol; typ <= r.typ; blk <= r.blk; saddr <= r.addr;
        daddr <= r.addr ^ 16'h0f00; cnt <= r.cnt; loop <= r.loop; dly <= r.dly;
        @(posedge clock_i);
        req <= r.req;
        sw <= r.sw;
        wait_hrq(1'b1, 20);
        wait_hrq(1'b0, 300);
        repeat (3) @(posedge clock_i);
        check("read_cycles", r.rd, n_rd);
        check("write_cycles", r.wr, n_wr);
        if (r.stb != 8'hff) check("strobes", r.stb, n_stb);
        check("hold_wait", r.loop ? 16'h1 : r.dly + 16'h2, n_wait);
        check("acked", (r.req & ~r.mask) | r.sw, served_q[0]);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{
            '{4'h1, 4'h0, 4'h0, 1'b0, dma_bm_pkg::XFER_READ, 1'b0, 16'h1234, 16'h0, 1'b1, 4'h0, 8'h3, 8'h0, 8'h1},
            '{4'h2, 4'h0, 4'h0, 1'b1, dma_bm_pkg::XFER_WRITE, 1'b0, 16'h5678, 16'h0, 1'b0, 4'h2, 8'h0, 8'h2, 8'h1},
            '{4'h4, 4'h0, 4'h0, 1'b0, dma_bm_pkg::XFER_VERIFY, 1'b0, 16'h9abc, 16'h0, 1'b1, 4'h0, 8'h0, 8'h0, 8'h1},
            '{4'h8, 4'h0, 4'h0, 1'b0, dma_bm_pkg::XFER_MEM2MEM, 1'b0, 16'h2040, 16'h0, 1'b1, 4'h0, 8'h3, 8'h2, 8'h2},
            '{4'h0, 4'hf, 4'h4, 1'b1, dma_bm_pkg::XFER_READ, 1'b0, 16'hc3a5, 16'h0, 1'b0, 4'h1, 8'h3, 8'h0, 8'h1},
            '{4'h1, 4'h0, 4'h0, 1'b0, dma_bm_pkg::XFER_READ, 1'b1, 16'h12fe, 16'h3, 1'b1, 4'h0, 8'hc, 8'h0, 8'h2},
            '{4'h2, 4'h0, 4'h0, 1'b1, dma_bm_pkg::XFER_WRITE, 1'b1, 16'h00ff, 16'h1, 1'b0, 4'h3, 8'h0, 8'h4, 8'h2},
            '{4'h4, 4'h0, 4'h0, 1'b0, dma_bm_pkg::XFER_VERIFY, 1'b1, 16'h4000, 16'h2, 1'b1, 4'h0, 8'h0, 8'h0, 8'h1}};
        repeat (10) @(posedge clock_i);
        // Reset values
        check("reset_pins", 16'h0f, {bus_hold_request, upper_addr_drive_enable, stb, mid_oe, low_oe, data_oe, rd_oe, wr_oe, ack});
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) run_row(rows[i]);
        // Masked hardware request is ignored until unmasked
        @(posedge clock_i);
        mask <= 4'h4; req <= 4'h4; pol <= 1'b0; loop <= 1'b1; blk <= 1'b0; cur_addr = saddr;
        repeat (12) @(posedge clock_i);
        check("masked_hrq", 16'h0, bus_hold_request);
        mask <= 4'h0;
        wait_hrq(1'b1, 20);
        wait_hrq(1'b0, 300);
        // Two requests: lowest index first, the other right after
        @(negedge clock_i);
        served_q.delete();
        @(posedge clock_i);
        req <= 4'ha;
        wait_hrq(1'b1, 20);
        wait_hrq(1'b0, 300);
        wait_hrq(1'b1, 20);
        wait_hrq(1'b0, 300);
        check("served_first", 16'h2, served_q[0]);
        check("served_second", 16'h8, served_q[1]);
        // Reset in mid-service releases every pin
        @(posedge clock_i);
        req <= 4'h1; blk <= 1'b1; cnt <= 16'h0040;
        k = 0;
        while (upper_addr_drive_enable !== 1'b1 && k < 20) begin
            @(posedge clock_i);
            k++;
        end
        arst_n_i <= 1'b0;
        req <= 4'h0;
        @(posedge clock_i);
        check("reset_mid", 16'h0f, {bus_hold_request, upper_addr_drive_enable, stb, mid_oe, low_oe, data_oe, rd_oe, wr_oe, ack});
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        check("reset_after", 16'h0f, {bus_hold_request, upper_addr_drive_enable, stb, mid_oe, low_oe, data_oe, rd_oe, wr_oe, ack});
        repeat (4) @(posedge clock_i);
        give_verdict();
    end
endmodule // dma_bus_master_signals_tb_top
